// File: dti_pkg.sv
// Package for the data transfer instruction unit
package dti_pkg;
	localparam logic [31:0] OFS_CMD    = 32'h0000_0000;
	localparam logic [31:0] OFS_ACC    = 32'h0000_0004;
	localparam logic [31:0] OFS_FLAG   = 32'h0000_0008;
	localparam logic [31:0] OFS_TIMER  = 32'h0000_000C;
	localparam logic [31:0] OFS_PORTA  = 32'h0000_0010;
	localparam logic [31:0] OFS_MEM    = 32'h0000_0100;
	localparam int          MEM_WORDS  = 64;
	localparam logic [7:0]  WORD_LIMIT = 8'h1F;
	localparam logic [7:0]  ZERO_BYTE  = 8'h00;
	localparam logic [1:0]  HTRANS_NSQ = 2'h2;
	// Command and flag register fields
	localparam int          CMD_OP_LSB = 8;
	localparam int          FLAG_Z     = 0;
	localparam int          FLAG_C     = 1;
	localparam int          FLAG_AC    = 2;
	localparam int          FLAG_OV    = 3;
	localparam int          FLAG_ERR   = 4;
	localparam int          FLAG_BUSY  = 5;

	typedef enum logic [2:0] {
		DTI_OP_IMM    = 3'h0,
		DTI_OP_ST_MEM = 3'h1,
		DTI_OP_LD_MEM = 3'h2,
		DTI_OP_LD_IO  = 3'h3,
		DTI_OP_ST_IO  = 3'h4,
		DTI_OP_TW_STO = 3'h5,
		DTI_OP_TW_LD  = 3'h6,
		DTI_OP_IDX    = 3'h7
	} dti_op_e;

	typedef enum logic [2:0] {
		DTI_ST_IDLE = 3'b001,
		DTI_ST_EXEC = 3'b010,
		DTI_ST_IND  = 3'b100
	} dti_state_e;

	typedef struct packed {
		logic       ov;
		logic       ac;
		logic       c;
		logic       z;
	} dti_flags_s;
endpackage

// File: dti_core.sv
// Data transfer instruction unit behind an AHB-Lite slave
//
// Notes on behaviour
// (RQ1) Immediate move puts operand in accumulator; all flags kept.
// (RQ2) Accumulator to memory store keeps all arithmetic flags.
// (RQ3) Memory to accumulator load sets zero flag from loaded byte.
// (RQ4) IO to accumulator load sets zero flag from loaded value.
// (RQ5) Accumulator to IO store keeps all flags.
// (RQ6) Timer word store copies 16-bit count to memory word; flags kept.
// (RQ7) Timer word load sets counter from memory word; flags kept.
// (RQ8) Indirect load reads byte via pointer word, two cycles, flags kept.
// (RQ9) Pointer low byte is target address; high byte expected zero.
// (RQ10) Word operands limited to addresses zero to thirty-one.
// (RQ11) Zero flag is one when result is zero, else zero.
// (RQ12) Word keeps low byte at lower address, high byte next.
`timescale 1ns/1ps
`default_nettype none
module dti_core (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [7:0]  port_a_register
);
	logic                   wr_q, wr_d;
	logic [31:0]            addr_q, addr_d;
	logic [31:0]            rdata_q, rdata_d;
	logic [7:0]             mem_q [dti_pkg::MEM_WORDS];
	logic [7:0]             accumulator_q, accumulator_d;
	dti_pkg::dti_flags_s    flags_q, flags_d;
	logic [15:0]            sixteen_bit_timer_q, sixteen_bit_timer_d;
	logic [7:0]             porta_q, porta_d;
	logic                   err_q, err_d;
	dti_pkg::dti_state_e    st_q, st_d;
	dti_pkg::dti_op_e       op_q, op_d;
	logic [7:0]             opnd_q, opnd_d;
	logic [7:0]             ptr_q, ptr_d;
	logic                   mem_we;
	logic [5:0]             mem_wa;
	logic [7:0]             mem_wd;
	logic                   mem_we2;
	logic [5:0]             mem_wa2;
	logic [7:0]             mem_wd2;
	logic                   take;
	logic                   cmd_wr;
	logic [5:0]             oa, oa1;
	logic                   word_ok;

	assign take    = hsel && hready && (htrans == dti_pkg::HTRANS_NSQ);
	assign cmd_wr  = wr_q && (addr_q == dti_pkg::OFS_CMD) && (st_q == dti_pkg::DTI_ST_IDLE);
	assign oa      = opnd_q[5:0];
	// (RQ12) high byte next
	assign oa1     = oa + 6'h01;
	// (RQ10) word range check
	assign word_ok = opnd_q <= dti_pkg::WORD_LIMIT;

	always_comb begin
		wr_d    = take ? hwrite : 1'b0;
		addr_d  = take ? haddr : '0;
		rdata_d = '0;
		if (take && !hwrite) begin
			if (haddr == dti_pkg::OFS_ACC)
				rdata_d = {24'h000000, accumulator_q};
			else if (haddr == dti_pkg::OFS_FLAG)
				rdata_d = {26'h0, st_q != dti_pkg::DTI_ST_IDLE, err_q, flags_q};
			else if (haddr == dti_pkg::OFS_TIMER)
				rdata_d = {16'h0000, sixteen_bit_timer_q};
			else if (haddr == dti_pkg::OFS_PORTA)
				rdata_d = {24'h000000, porta_q};
			else if (haddr[31:8] == dti_pkg::OFS_MEM[31:8] &&
				{1'b0, haddr[7:2]} < 7'(dti_pkg::MEM_WORDS))
				rdata_d = {24'h000000, mem_q[haddr[7:2]]};
		end
	end

	always_comb begin
		st_d                = st_q;
		op_d                = op_q;
		opnd_d              = opnd_q;
		ptr_d               = ptr_q;
		accumulator_d       = accumulator_q;
		flags_d             = flags_q;
		sixteen_bit_timer_d = sixteen_bit_timer_q + 16'h0001;
		porta_d             = porta_q;
		err_d               = err_q;
		mem_we  = 1'b0;
		mem_wa  = '0;
		mem_wd  = '0;
		mem_we2 = 1'b0;
		mem_wa2 = '0;
		mem_wd2 = '0;
		unique case (st_q)
			dti_pkg::DTI_ST_IDLE: begin
				if (cmd_wr) begin
					op_d   = dti_pkg::dti_op_e'(hwdata[dti_pkg::CMD_OP_LSB +: 3]);
					opnd_d = hwdata[7:0];
					err_d  = 1'b0;
					st_d   = dti_pkg::DTI_ST_EXEC;
				end else if (wr_q && addr_q == dti_pkg::OFS_TIMER) begin
					sixteen_bit_timer_d = hwdata[15:0];
				end else if (wr_q && addr_q[31:8] == dti_pkg::OFS_MEM[31:8]) begin
					mem_we = 1'b1;
					mem_wa = addr_q[7:2];
					mem_wd = hwdata[7:0];
				end
			end
			dti_pkg::DTI_ST_EXEC: begin
				st_d = dti_pkg::DTI_ST_IDLE;
				unique case (op_q)
					// (RQ1) immediate load
					dti_pkg::DTI_OP_IMM: accumulator_d = opnd_q;
					// (RQ2) store to memory
					dti_pkg::DTI_OP_ST_MEM: begin
						mem_we = 1'b1;
						mem_wa = oa;
						mem_wd = accumulator_q;
					end
					// (RQ3) (RQ11) load with zero flag
					dti_pkg::DTI_OP_LD_MEM: begin
						accumulator_d = mem_q[oa];
						flags_d.z     = mem_q[oa] == dti_pkg::ZERO_BYTE;
					end
					// (RQ4) IO load with zero flag
					dti_pkg::DTI_OP_LD_IO: begin
						accumulator_d = porta_q;
						flags_d.z     = porta_q == dti_pkg::ZERO_BYTE;
					end
					// (RQ5) IO store
					dti_pkg::DTI_OP_ST_IO: porta_d = accumulator_q;
					// (RQ6) timer to memory word
					dti_pkg::DTI_OP_TW_STO: begin
						if (word_ok) begin
							mem_we  = 1'b1;
							mem_wa  = oa;
							mem_wd  = sixteen_bit_timer_q[7:0];
							mem_we2 = 1'b1;
							mem_wa2 = oa1;
							mem_wd2 = sixteen_bit_timer_q[15:8];
						end else err_d = 1'b1;
					end
					// (RQ7) memory word to timer
					dti_pkg::DTI_OP_TW_LD: begin
						if (word_ok) sixteen_bit_timer_d = {mem_q[oa1], mem_q[oa]};
						else err_d = 1'b1;
					end
					// (RQ8) (RQ9) fetch pointer low byte
					dti_pkg::DTI_OP_IDX: begin
						if (word_ok) begin
							ptr_d = mem_q[oa];
							err_d = mem_q[oa1] != dti_pkg::ZERO_BYTE;
							st_d  = dti_pkg::DTI_ST_IND;
						end else err_d = 1'b1;
					end
				endcase
			end
			dti_pkg::DTI_ST_IND: begin
				// (RQ8) second cycle, flags kept
				accumulator_d = mem_q[ptr_q[5:0]];
				st_d          = dti_pkg::DTI_ST_IDLE;
			end
			default: st_d = dti_pkg::DTI_ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q                <= 1'b0;
			addr_q              <= '0;
			rdata_q             <= '0;
			accumulator_q       <= '0;
			flags_q             <= '0;
			sixteen_bit_timer_q <= '0;
			porta_q             <= '0;
			err_q               <= 1'b0;
			st_q                <= dti_pkg::DTI_ST_IDLE;
			op_q                <= dti_pkg::DTI_OP_IMM;
			opnd_q              <= '0;
			ptr_q               <= '0;
			port_a_register     <= '0;
		end else begin
			wr_q                <= wr_d;
			addr_q              <= addr_d;
			rdata_q             <= rdata_d;
			accumulator_q       <= accumulator_d;
			flags_q             <= flags_d;
			sixteen_bit_timer_q <= sixteen_bit_timer_d;
			porta_q             <= porta_d;
			err_q               <= err_d;
			st_q                <= st_d;
			op_q                <= op_d;
			opnd_q              <= opnd_d;
			ptr_q               <= ptr_d;
			port_a_register     <= porta_d;
		end
	end

	// Data memory has no reset, as real SRAM would not
	always_ff @(posedge hclk) begin
		if (mem_we) mem_q[mem_wa] <= mem_wd;
		if (mem_we2) mem_q[mem_wa2] <= mem_wd2;
	end

	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	property p_imm_load;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == dti_pkg::DTI_ST_EXEC && op_q == dti_pkg::DTI_OP_IMM)
			|=> (accumulator_q == $past(opnd_q) && flags_q == $past(flags_q));
	endproperty
	a_imm_load: assert property (p_imm_load) else $error("immediate load wrong"); // RQ1

	property p_ld_zero;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == dti_pkg::DTI_ST_EXEC && (op_q == dti_pkg::DTI_OP_LD_MEM ||
			op_q == dti_pkg::DTI_OP_LD_IO))
			|=> (flags_q.z == (accumulator_q == dti_pkg::ZERO_BYTE)) && $stable(flags_q.c);
	endproperty
	a_ld_zero: assert property (p_ld_zero) else $error("zero flag wrong after load"); // RQ3

	property p_io_store;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == dti_pkg::DTI_ST_EXEC && op_q == dti_pkg::DTI_OP_ST_IO)
			|=> ##1 (port_a_register == $past(accumulator_q, 2));
	endproperty
	a_io_store: assert property (p_io_store) else $error("IO store wrong"); // RQ5

	property p_idx_two;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == dti_pkg::DTI_ST_EXEC && op_q == dti_pkg::DTI_OP_IDX && word_ok)
			|=> st_q == dti_pkg::DTI_ST_IND ##1 st_q == dti_pkg::DTI_ST_IDLE;
	endproperty
	a_idx_two: assert property (p_idx_two) else $error("indirect load not two cycles"); // RQ8

	property p_flags_kept;
		@(posedge hclk) disable iff (!hresetn)
		(st_q != dti_pkg::DTI_ST_IDLE && op_q != dti_pkg::DTI_OP_LD_MEM &&
			op_q != dti_pkg::DTI_OP_LD_IO) |=> $stable(flags_q);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flags changed"); // RQ2

	property p_tw_load;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == dti_pkg::DTI_ST_EXEC && op_q == dti_pkg::DTI_OP_TW_LD && word_ok)
			|=> sixteen_bit_timer_q == {$past(mem_q[oa1]), $past(mem_q[oa])};
	endproperty
	a_tw_load: assert property (p_tw_load) else $error("timer word load wrong"); // RQ7

	property p_word_range;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == dti_pkg::DTI_ST_EXEC && op_q >= dti_pkg::DTI_OP_TW_STO && !word_ok)
			|=> err_q && st_q == dti_pkg::DTI_ST_IDLE;
	endproperty
	a_word_range: assert property (p_word_range) else $error("word range not enforced"); // RQ10

	property p_tw_store;
		@(posedge hclk) disable iff (!hresetn)
		(st_q == dti_pkg::DTI_ST_EXEC && op_q == dti_pkg::DTI_OP_TW_STO && word_ok)
			|=> mem_q[$past(oa1)] == $past(sixteen_bit_timer_q[15:8]);
	endproperty
	a_tw_store: assert property (p_tw_store) else $error("timer word store wrong"); // RQ6
endmodule // dti_core
`default_nettype wire

// File: dti_host.sv
// AHB-Lite master standing on the host side of the transfer unit
`timescale 1ns/1ps
`default_nettype none
module dti_host (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// Entered just after a rising edge; returns at the edge ending the data phase
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= dti_pkg::HTRANS_NSQ;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
endmodule // dti_host
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the data transfer instruction unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  port_a_register;
	logic [31:0] r;
	int          err_total;
	int          cmp_count;
	int          mem_m [64];
	int          acc_m;
	int          i;
	int          t;
	int          v;
	always #4 hclk = ~hclk;
	dti_core u_dti_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.port_a_register(port_a_register));
	dti_host u_dti_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [31:0] a, logic [31:0] d);
		u_dti_host.xfer(1'b1, a, d, r);
	endtask
	task automatic rd(logic [31:0] a);
		u_dti_host.xfer(1'b0, a, 32'h0, r);
	endtask
	task automatic wm(int a, int d);
		mem_m[a] = d;
		wr(dti_pkg::OFS_MEM + 32'(4 * a), 32'(d));
	endtask
	task automatic rm(int a);
		rd(dti_pkg::OFS_MEM + 32'(4 * a));
		chk("mem", 32'(mem_m[a]), r);
	endtask
	// Busy is polled, never assumed gone after a fixed time
	task automatic cmd(dti_pkg::dti_op_e op, logic [7:0] x);
		wr(dti_pkg::OFS_CMD, {21'h0, op, x});
		for (t = 0; t < 20; t++) begin
			rd(dti_pkg::OFS_FLAG);
			if (r[dti_pkg::FLAG_BUSY] === 1'b0) break;
		end
		chk("busy", 32'h0, {31'h0, r[dti_pkg::FLAG_BUSY]});
	endtask
	// Carry, aux carry and overflow must stay clear throughout
	task automatic st(logic e, logic z);
		rd(dti_pkg::OFS_ACC);
		chk("acc", 32'(acc_m), r);
		rd(dti_pkg::OFS_FLAG);
		chk("flag", {26'h0, 1'b0, e, 3'h0, z}, r & 32'h3F);
	endtask
	task automatic conclude();
		if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		conclude();
	end
	initial begin
		i = $urandom(2142);
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		wm(2, 0);
		for (i = 0; i < 4; i++) begin
			v = $urandom_range(255, 1);
			cmd(dti_pkg::DTI_OP_LD_MEM, 8'h02);
			acc_m = 0;
			st(1'b0, 1'b1);
			cmd(dti_pkg::DTI_OP_IMM, v[7:0]);
			acc_m = v;
			st(1'b0, 1'b1);
			cmd(dti_pkg::DTI_OP_ST_MEM, 8'(32 + i));
			mem_m[32 + i] = v;
			rm(32 + i);
			cmd(dti_pkg::DTI_OP_ST_IO, dti_pkg::OFS_PORTA[7:0]);
			chk("port_a", 32'(v), {24'h0, port_a_register});
			st(1'b0, 1'b1);
			cmd(dti_pkg::DTI_OP_LD_MEM, 8'h02);
			cmd(dti_pkg::DTI_OP_LD_IO, dti_pkg::OFS_PORTA[7:0]);
			st(1'b0, 1'b0);
			cmd(dti_pkg::DTI_OP_LD_MEM, 8'h02);
			cmd(dti_pkg::DTI_OP_LD_MEM, 8'(32 + i));
			st(1'b0, 1'b0);
		end
		wm(10, 33);
		wm(11, 0);
		cmd(dti_pkg::DTI_OP_LD_MEM, 8'h02);
		cmd(dti_pkg::DTI_OP_IDX, 8'h0A);
		acc_m = mem_m[33];
		st(1'b0, 1'b1);
		wm(10, 32);
		wm(11, 1);
		cmd(dti_pkg::DTI_OP_IDX, 8'h0A);
		acc_m = mem_m[32];
		st(1'b1, 1'b1);
		wm(4, 8'h34);
		wm(5, 8'h12);
		cmd(dti_pkg::DTI_OP_TW_LD, 8'h04);
		cmd(dti_pkg::DTI_OP_TW_STO, 8'h08);
		rd(dti_pkg::OFS_MEM + 32'h24);
		v = int'(r[7:0]) * 256;
		rd(dti_pkg::OFS_MEM + 32'h20);
		v = v + int'(r[7:0]) - 32'h1234;
		// Timer runs on between load and store, so only a small gain is allowed
		chk("timer_gain", 32'h1, {31'h0, v >= 1 && v <= 60});
		st(1'b0, 1'b1);
		cmd(dti_pkg::DTI_OP_TW_STO, 8'h20);
		rm(32);
		st(1'b1, 1'b1);
		conclude();
	end
endmodule // tb_top
`default_nettype wire
